// >>> sac_asserts.sv
`timescale 1ns/10ps
`default_nettype none

module sac_asserts
    import sac_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic pinModeSel,
    input wire logic pinStrobe,
    input wire logic pinSerClk,
    input wire logic pinSerData,
    input wire logic [WEIGHT_W-1:0] pinWeights,
    input wire logic [WEIGHT_W-1:0] attenCode,
    input wire logic serialMode,
    input wire logic wordBitSeven,
    input wire logic [COUNT_W-1:0] bitsReceived
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    // ----
    // Link checks
    // ----
    chk_par_ser_low: assert property (!pinModeSel |-> !pinSerClk && !pinSerData)
        else $error("serial pins busy in parallel");
    chk_mode_sync: assert property ($stable(pinModeSel) [*4] |-> serialMode == pinModeSel)
        else $error("mode not followed");
    chk_direct_follow: assert property (
        (!pinModeSel && pinStrobe && $stable(pinWeights)) [*6] |-> attenCode == pinWeights)
        else $error("code not following weights");
    chk_hold_low: assert property (!pinStrobe [*4] |=> $stable(attenCode))
        else $error("code moved while strobe low");
    chk_count_cap: assert property (bitsReceived <= COUNT_FULL)
        else $error("bit count over eight");
    chk_clk_phase: assert property ($changed(pinSerClk) |=> $stable(pinSerClk) [*2])
        else $error("serial clock phase short");
    chk_strobe_width: assert property ($rose(pinStrobe) |=> pinStrobe [*2])
        else $error("strobe pulse short");
    chk_strobe_after: assert property ($rose(pinStrobe) |-> !pinSerClk && !$past(pinSerClk))
        else $error("strobe too close to clock");
    chk_bit_seven: assert property (!wordBitSeven)
        else $error("word bit seven set");

    // Main scenarios reached
    cover property ($rose(pinStrobe) && pinModeSel);
    cover property (bitsReceived == COUNT_FULL);
    cover property (attenCode == 7'h7F);
endmodule // sac_asserts

`default_nettype wire

// >>> sac_controller.sv
`timescale 1ns/10ps
`default_nettype none

module sac_controller
    import sac_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic awvalid,
    output logic awready,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [STRB_W-1:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [ADDR_W-1:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    sac_link_if.ctrl link
);

    // ------------------------------------------------------------
    // Write channels
    // ------------------------------------------------------------
    logic awHave_reg, wHave_reg, awReady_reg, wReady_reg, bValid_reg;
    logic awHave_next, wHave_next, wrDone, doWrite, wrOk, idle;
    logic wrLane_reg;
    logic [1:0] bResp_reg;
    logic [ADDR_W-1:0] wrAddr_reg;
    logic [WORD_W-1:0] wrByte_reg;
    logic wrCtrl, wrAtten;
    sac_state_t state_reg;

    assign wrDone = bValid_reg & bready;
    assign awHave_next = (awHave_reg | (awvalid & awReady_reg)) & ~wrDone;
    assign wHave_next = (wHave_reg | (wvalid & wReady_reg)) & ~wrDone;
    assign doWrite = awHave_reg & wHave_reg & ~bValid_reg;
    assign idle = (state_reg == ST_IDLE);
    assign wrOk = idle & (wrAddr_reg == REG_CTRL | wrAddr_reg == REG_ATTEN);
    assign wrCtrl = doWrite & wrOk & wrLane_reg & (wrAddr_reg == REG_CTRL);
    assign wrAtten = doWrite & wrOk & wrLane_reg & (wrAddr_reg == REG_ATTEN);

    // Address and data taken in either order, answer after both
    always_ff @(posedge mclk) begin
        if (srst) begin
            awHave_reg <= 1'h0;
            wHave_reg <= 1'h0;
            awReady_reg <= 1'h0;
            wReady_reg <= 1'h0;
            bValid_reg <= 1'h0;
            bResp_reg <= RESP_OKAY;
        end else begin
            awHave_reg <= awHave_next;
            wHave_reg <= wHave_next;
            awReady_reg <= ~awHave_next;
            wReady_reg <= ~wHave_next;
            if (doWrite) begin
                bValid_reg <= 1'h1;
                bResp_reg <= wrOk ? RESP_OKAY : RESP_SLVERR;
            end else if (wrDone) begin
                bValid_reg <= 1'h0;
            end
        end
    end

    // Captured write payload
    always_ff @(posedge mclk) begin
        if (srst) begin
            wrAddr_reg <= REG_CTRL;
            wrByte_reg <= WORD_RESET;
            wrLane_reg <= 1'h0;
        end else begin
            if (awvalid && awReady_reg) begin
                wrAddr_reg <= awaddr;
            end
            if (wvalid && wReady_reg) begin
                wrByte_reg <= wdata[WORD_W-1:0];
                wrLane_reg <= wstrb[0];
            end
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    logic serial_reg, latched_reg, driveEn_reg;
    logic [WEIGHT_W-1:0] code_reg;

    // Mode, latch and drive selection; requested code
    always_ff @(posedge mclk) begin
        if (srst) begin
            serial_reg <= 1'h0;
            latched_reg <= 1'h0;
            driveEn_reg <= 1'h0;
            code_reg <= ATTEN_RESET;
        end else if (wrCtrl) begin
            serial_reg <= wrByte_reg[CTRL_SERIAL_BIT];
            latched_reg <= wrByte_reg[CTRL_LATCHED_BIT];
            driveEn_reg <= wrByte_reg[CTRL_DRIVE_BIT];
        end else if (wrAtten) begin
            code_reg <= wrByte_reg[WEIGHT_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    logic arReady_reg, rValid_reg, rValid_next;
    logic [DATA_W-1:0] rData_reg;
    logic [1:0] rResp_reg;

    assign rValid_next = (rValid_reg & ~rready) | (arvalid & arReady_reg);

    // Read decode and answer
    always_ff @(posedge mclk) begin
        if (srst) begin
            arReady_reg <= 1'h0;
            rValid_reg <= 1'h0;
            rData_reg <= '0;
            rResp_reg <= RESP_OKAY;
        end else begin
            arReady_reg <= ~rValid_next;
            rValid_reg <= rValid_next;
            if (arvalid && arReady_reg) begin
                rResp_reg <= RESP_OKAY;
                case (araddr)
                    REG_CTRL: rData_reg <= DATA_W'({driveEn_reg, latched_reg, serial_reg});
                    REG_ATTEN: rData_reg <= DATA_W'(code_reg);
                    REG_STATUS: rData_reg <= DATA_W'(~idle);
                    default: begin
                        rData_reg <= '0;
                        rResp_reg <= RESP_SLVERR;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Link sequencer
    // ------------------------------------------------------------
    logic [CNT_W-1:0] cnt_reg;
    logic [2:0] bitIdx_reg;
    logic [WORD_W-1:0] word_reg;
    logic mode_reg, strobe_reg, sclk_reg, sdata_reg, driveN_reg;
    logic [WEIGHT_W-1:0] weights_reg;
    logic cntDone;

    assign cntDone = (cnt_reg == CNT_LAST);

    // Drives the pins through parallel and serial sequences
    always_ff @(posedge mclk) begin
        if (srst) begin
            state_reg <= ST_IDLE;
            cnt_reg <= CNT_LAST;
            bitIdx_reg <= 3'h0;
            word_reg <= WORD_RESET;
            mode_reg <= 1'h0;
            strobe_reg <= 1'h1;
            sclk_reg <= 1'h0;
            sdata_reg <= 1'h0;
            weights_reg <= ATTEN_RESET;
            driveN_reg <= 1'h1;
        end else begin
            if (!cntDone) begin
                cnt_reg <= cnt_reg - CNT_LAST;
            end
            case (state_reg)
                ST_IDLE: begin
                    if (wrCtrl) begin
                        mode_reg <= wrByte_reg[CTRL_SERIAL_BIT];
                        driveN_reg <= ~wrByte_reg[CTRL_DRIVE_BIT];
                        weights_reg <= ATTEN_RESET;
                        sclk_reg <= 1'h0;
                        sdata_reg <= 1'h0;
                        // Direct parallel keeps strobe high
                        strobe_reg <= ~wrByte_reg[CTRL_SERIAL_BIT]
                                      & ~wrByte_reg[CTRL_LATCHED_BIT];
                        cnt_reg <= MODE_SETUP_CYC;
                        state_reg <= ST_HOLD;
                    end else if (wrAtten && serial_reg) begin
                        word_reg <= {1'h0, wrByte_reg[WEIGHT_W-1:0]};
                        sdata_reg <= wrByte_reg[0];
                        bitIdx_reg <= 3'h0;
                        cnt_reg <= SER_HALF_CYC;
                        state_reg <= ST_SCLK_LOW;
                    end else if (wrAtten) begin
                        weights_reg <= wrByte_reg[WEIGHT_W-1:0];
                        cnt_reg <= DATA_SETUP_CYC;
                        state_reg <= ST_SETUP;
                    end
                end
                ST_SETUP: if (cntDone) begin
                    if (latched_reg) begin
                        strobe_reg <= 1'h1;
                        cnt_reg <= STROBE_WIDTH_CYC;
                        state_reg <= ST_STROBE;
                    end else begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_STROBE: if (cntDone) begin
                    strobe_reg <= 1'h0;
                    cnt_reg <= DATA_HOLD_CYC;
                    state_reg <= ST_HOLD;
                end
                ST_HOLD: if (cntDone) begin
                    state_reg <= ST_IDLE;
                end
                ST_SCLK_LOW: if (cntDone) begin
                    sclk_reg <= 1'h1;
                    cnt_reg <= SER_HALF_CYC;
                    state_reg <= ST_SCLK_HIGH;
                end
                ST_SCLK_HIGH: if (cntDone) begin
                    sclk_reg <= 1'h0;
                    cnt_reg <= SER_HALF_CYC;
                    if (bitIdx_reg == LAST_BIT) begin
                        cnt_reg <= STROBE_AFTER_CYC;
                        state_reg <= ST_LESU;
                    end else begin
                        bitIdx_reg <= bitIdx_reg + 3'h1;
                        sdata_reg <= word_reg[bitIdx_reg + 3'h1];
                        state_reg <= ST_SCLK_LOW;
                    end
                end
                ST_LESU: if (cntDone) begin
                    sdata_reg <= 1'h0;
                    strobe_reg <= 1'h1;
                    cnt_reg <= STROBE_WIDTH_CYC;
                    state_reg <= ST_STROBE;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign awready = awReady_reg;
    assign wready = wReady_reg;
    assign bvalid = bValid_reg;
    assign bresp = bResp_reg;
    assign arready = arReady_reg;
    assign rvalid = rValid_reg;
    assign rdata = rData_reg;
    assign rresp = rResp_reg;
    assign link.ctlModeSel = mode_reg;
    assign link.ctlStrobe = strobe_reg;
    assign link.ctlSerClk = sclk_reg;
    assign link.ctlSerData = sdata_reg;
    assign link.ctlWeights = weights_reg;
    assign link.ctlDriveN = driveN_reg;

endmodule // sac_controller

`default_nettype wire

// >>> sac_device.sv
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - Mode pin high serial, low parallel
// - Seven weights sum to attenuation code
// - Parallel mode: controller holds serial pins low
// - All low reference, all high 31.75 dB
// - Latched: capture on rise, pass high, hold low
// - Strobe held high: attenuation follows weights
// - Serial mode: controller holds weights low
// - Word bits zero to six weight quarter upward
// - Serial data sampled on serial clock rise
// - Word sent and assembled LSB first
// - Shift only while strobe low, output unchanged
// - Controller raises strobe after full word
// - Strobe high applies shift register contents
// - Strobe rise at least 10 ns after clock
// - Serial clock max 10 MHz, phases 30 ns
// - Strobe pulses at least 30 ns wide
// - Undriven weights, data, clock, mode read low
// - Undriven strobe reads high, giving direct mode
module sac_device
    import sac_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    sac_link_if.atten link,
    output logic [WEIGHT_W-1:0] attenCode,
    output logic serialMode,
    output logic wordBitSeven,
    output logic [COUNT_W-1:0] bitsReceived
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [3:0] ctlPins;
    logic [3:0] ctlSync;
    logic [WEIGHT_W-1:0] weightSync;
    logic modeS;
    logic strobeS;
    logic sclkS;
    logic sdataS;

    // Control pins, pulls already resolved on the link
    assign ctlPins = {link.pinModeSel, link.pinStrobe, link.pinSerClk,
                      link.pinSerData};

    sac_sync #(
        .WIDTH(4)
    ) u_ctl_sync (
        .mclk(mclk),
        .srst(srst),
        .asyncIn(ctlPins),
        .syncOut(ctlSync)
    );

    sac_sync #(
        .WIDTH(WEIGHT_W)
    ) u_weight_sync (
        .mclk(mclk),
        .srst(srst),
        .asyncIn(link.pinWeights),
        .syncOut(weightSync)
    );

    // Named views of the synchronised control pins
    assign modeS = ctlSync[3];
    assign strobeS = ctlSync[2];
    assign sclkS = ctlSync[1];
    assign sdataS = ctlSync[0];

    // ------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------
    logic sclkPrev_reg;
    logic strobePrev_reg;
    logic sclkRise;
    logic strobeRise;

    // Previous levels of clock and strobe
    always_ff @(posedge mclk) begin
        if (srst) begin
            sclkPrev_reg <= PULL_DOWN_LVL;
            strobePrev_reg <= PULL_DOWN_LVL;
        end else begin
            sclkPrev_reg <= sclkS;
            strobePrev_reg <= strobeS;
        end
    end

    assign sclkRise = sclkS & ~sclkPrev_reg;
    assign strobeRise = strobeS & ~strobePrev_reg;

    // ------------------------------------------------------------
    // Serial shift register
    // ------------------------------------------------------------
    logic [WORD_W-1:0] shiftWord_reg;
    logic [WORD_W-1:0] shiftWord_next;
    logic shiftEn;

    // Shift only in serial mode with the strobe low
    assign shiftEn = modeS & sclkRise & ~strobeS;

    // New bit enters at the top, so the first bit lands in bit zero
    always_comb begin
        shiftWord_next = shiftWord_reg;
        if (shiftEn) begin
            shiftWord_next = {sdataS, shiftWord_reg[WORD_W-1:1]};
        end
    end

    // Shift register state
    always_ff @(posedge mclk) begin
        if (srst) begin
            shiftWord_reg <= WORD_RESET;
        end else begin
            shiftWord_reg <= shiftWord_next;
        end
    end

    // ------------------------------------------------------------
    // Bit counter
    // ------------------------------------------------------------
    logic [COUNT_W-1:0] bitCount_reg;

    // Counts bits since the last load, saturating at a full word
    always_ff @(posedge mclk) begin
        if (srst) begin
            bitCount_reg <= COUNT_RESET;
        end else if (strobeRise) begin
            bitCount_reg <= COUNT_RESET;
        end else if (shiftEn && bitCount_reg != COUNT_FULL) begin
            bitCount_reg <= bitCount_reg + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // Attenuation control latch
    // ------------------------------------------------------------
    logic [WEIGHT_W-1:0] atten_reg;
    logic [WEIGHT_W-1:0] loadSource;
    logic bitSeven_reg;
    logic serialMode_reg;

    // Source of the applied code by mode
    always_comb begin
        if (modeS) begin
            // Bits zero..six carry quarter dB up to sixteen dB
            loadSource = shiftWord_next[WEIGHT_W-1:0];
        end else begin
            // Weight bit i is worth 2^i quarter dB; code is the sum
            loadSource = weightSync;
        end
    end

    // Transparent while strobe high, holds while low
    always_ff @(posedge mclk) begin
        if (srst) begin
            atten_reg <= ATTEN_RESET;
        end else if (strobeS) begin
            atten_reg <= loadSource;
        end
    end

    // Bit seven of the last applied serial word, for inspection
    always_ff @(posedge mclk) begin
        if (srst) begin
            bitSeven_reg <= PULL_DOWN_LVL;
        end else if (strobeS) begin
            bitSeven_reg <= modeS & shiftWord_next[WORD_W-1];
        end
    end

    // Current programming mode
    always_ff @(posedge mclk) begin
        if (srst) begin
            serialMode_reg <= PULL_DOWN_LVL;
        end else begin
            serialMode_reg <= modeS;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign attenCode = atten_reg;
    assign serialMode = serialMode_reg;
    assign wordBitSeven = bitSeven_reg;
    assign bitsReceived = bitCount_reg;

endmodule // sac_device

`default_nettype wire

// >>> sac_link_if.sv
`timescale 1ns/10ps
`default_nettype none

interface sac_link_if;
    import sac_pkg::*;

    // Levels the controller drives, and its drive enable (low drives)
    logic ctlModeSel;
    logic ctlStrobe;
    logic ctlSerClk;
    logic ctlSerData;
    logic [WEIGHT_W-1:0] ctlWeights;
    logic ctlDriveN;

    // Pin levels as the attenuator sees them
    logic pinModeSel;
    logic pinStrobe;
    logic pinSerClk;
    logic pinSerData;
    logic [WEIGHT_W-1:0] pinWeights;

    // Undriven pins fall to their internal pulls
    assign pinModeSel = ctlDriveN ? PULL_DOWN_LVL : ctlModeSel;
    assign pinSerClk = ctlDriveN ? PULL_DOWN_LVL : ctlSerClk;
    assign pinSerData = ctlDriveN ? PULL_DOWN_LVL : ctlSerData;
    assign pinWeights = ctlDriveN ? {WEIGHT_W{PULL_DOWN_LVL}} : ctlWeights;
    assign pinStrobe = ctlDriveN ? PULL_UP_LVL : ctlStrobe;

    modport ctrl (
        output ctlModeSel,
        output ctlStrobe,
        output ctlSerClk,
        output ctlSerData,
        output ctlWeights,
        output ctlDriveN
    );

    modport atten (
        input pinModeSel,
        input pinStrobe,
        input pinSerClk,
        input pinSerData,
        input pinWeights
    );

endinterface // sac_link_if

`default_nettype wire

// >>> sac_pkg.sv
package sac_pkg;

    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int WEIGHT_W = 7;
    localparam int WORD_W = 8;
    localparam int COUNT_W = 4;
    localparam int CNT_W = 4;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;
    localparam logic [WEIGHT_W-1:0] ATTEN_RESET = 7'h00;
    localparam logic [WORD_W-1:0] WORD_RESET = 8'h00;
    localparam logic [COUNT_W-1:0] COUNT_RESET = 4'h0;
    localparam logic [COUNT_W-1:0] COUNT_FULL = 4'h8;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic PULL_DOWN_LVL = 1'h0;
    localparam logic PULL_UP_LVL = 1'h1;

    // ------------------------------------------------------------
    // Link timing, ns and derived mclk cycles
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int SER_HALF_NS = 50;
    localparam int STROBE_AFTER_LAST_EDGE_NS = 10;
    localparam int STROBE_MIN_WIDTH_NS = 30;
    localparam int DATA_SETUP_NS = 100;
    localparam int DATA_HOLD_NS = 100;
    localparam int MODE_SETUP_NS = 100;
    localparam logic [CNT_W-1:0] SER_HALF_CYC =
        CNT_W'((SER_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] STROBE_AFTER_CYC =
        CNT_W'((STROBE_AFTER_LAST_EDGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] STROBE_WIDTH_CYC =
        CNT_W'((STROBE_MIN_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] DATA_SETUP_CYC =
        CNT_W'((DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] DATA_HOLD_CYC =
        CNT_W'((DATA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] MODE_SETUP_CYC =
        CNT_W'((MODE_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] CNT_LAST = 4'h1;

    // ------------------------------------------------------------
    // Controller register map
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] REG_ATTEN = 4'h4;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h8;
    localparam int CTRL_SERIAL_BIT = 0;
    localparam int CTRL_LATCHED_BIT = 1;
    localparam int CTRL_DRIVE_BIT = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Controller sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_SETUP = 3'h1,
        ST_STROBE = 3'h2,
        ST_HOLD = 3'h3,
        ST_SCLK_LOW = 3'h4,
        ST_SCLK_HIGH = 3'h5,
        ST_LESU = 3'h6
    } sac_state_t;

endpackage

// >>> sac_sync.sv
`timescale 1ns/10ps
`default_nettype none

// Two-stage synchroniser for pin levels
module sac_sync #(
    parameter int WIDTH = 1
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] stable_reg;

    // First stage feeds only the second
    always_ff @(posedge mclk) begin
        if (srst) begin
            meta_reg <= '0;
            stable_reg <= '0;
        end else begin
            meta_reg <= asyncIn;
            stable_reg <= meta_reg;
        end
    end

    assign syncOut = stable_reg;

endmodule // sac_sync

`default_nettype wire

// >>> step_attenuator_control_tb.sv
`timescale 1ns/10ps
`default_nettype none

module step_attenuator_control_tb;
    import sac_pkg::*;
    logic mclk, srst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, serialMode, wordBitSeven;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [DATA_W-1:0] wdata, rdata, rd;
    logic [STRB_W-1:0] wstrb;
    logic [1:0] bresp, rresp, rs;
    logic [WEIGHT_W-1:0] attenCode;
    logic [COUNT_W-1:0] bitsReceived;
    int mismatches, testsRun;

    sac_link_if link ();
    sac_controller sac_controller_inst (.mclk(mclk), .srst(srst), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
        .rresp(rresp), .link(link.ctrl));
    sac_device sac_device_inst (.mclk(mclk), .srst(srst), .link(link.atten),
        .attenCode(attenCode), .serialMode(serialMode), .wordBitSeven(wordBitSeven),
        .bitsReceived(bitsReceived));
    sac_asserts sac_asserts_inst (.mclk(mclk), .srst(srst), .pinModeSel(link.pinModeSel),
        .pinStrobe(link.pinStrobe), .pinSerClk(link.pinSerClk), .pinSerData(link.pinSerData),
        .pinWeights(link.pinWeights), .attenCode(attenCode), .serialMode(serialMode),
        .wordBitSeven(wordBitSeven), .bitsReceived(bitsReceived));

    // Clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // ----
    // Bus and compare tasks
    // ----
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        testsRun++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge mclk);
        {awvalid, wvalid, bready} <= 3'h7;
        awaddr <= a;
        wdata <= d;
        forever begin
            @(posedge mclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                rs = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic rdr(input logic [ADDR_W-1:0] a);
        @(posedge mclk);
        {arvalid, rready} <= 2'h3;
        araddr <= a;
        forever begin
            @(posedge mclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                {rd, rs} = {rdata, rresp};
                rready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic set_mode(input logic [DATA_W-1:0] c);
        wr(REG_CTRL, c);
        do rdr(REG_STATUS); while (rd[0] !== 1'b0);
    endtask

    task automatic apply(input logic [WEIGHT_W-1:0] code);
        wr(REG_ATTEN, 32'(code));
        check("resp", 32'(RESP_OKAY), 32'(rs));
        do rdr(REG_STATUS); while (rd[0] !== 1'b0);
        check("attenCode", 32'(code), 32'(attenCode));
        check("wordBitSeven", 32'h0, 32'(wordBitSeven));
    endtask

    // Every weight alone, then none and all
    task automatic sweep;
        for (int i = 0; i < WEIGHT_W; i++) apply(7'(1 << i));
        apply(7'h00);
        apply(7'h7F);
    endtask

    task automatic refusals;
        wr(REG_ATTEN, 32'h15);
        wr(REG_ATTEN, 32'h6A);
        check("busy resp", 32'(RESP_SLVERR), 32'(rs));
        wr(REG_STATUS, 32'h1);
        check("ro resp", 32'(RESP_SLVERR), 32'(rs));
        rdr(4'hC);
        check("unmapped resp", 32'(RESP_SLVERR), 32'(rs));
        check("unmapped data", 32'h0, rd);
        do rdr(REG_STATUS); while (rd[0] !== 1'b0);
        wstrb <= 4'h0;
        wr(REG_ATTEN, 32'h7F);
        check("no lane resp", 32'(RESP_OKAY), 32'(rs));
        wstrb <= 4'hF;
        rdr(REG_ATTEN);
        check("code reg", 32'h15, rd);
        rdr(REG_CTRL);
        check("ctrl reg", 32'h4, rd);
        check("kept code", 32'h15, 32'(attenCode));
    endtask

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", testsRun, mismatches);
        if (mismatches == 0 && testsRun > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        {srst, wstrb} = {1'b1, 4'hF};
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        {awaddr, araddr, wdata} = '0;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        repeat (6) @(posedge mclk);
        check("float code", 32'h0, 32'(attenCode));
        set_mode(32'h4);
        sweep();
        refusals();
        set_mode(32'h6);
        apply(7'h2A);
        apply(7'h55);
        set_mode(32'h2);
        check("float strobe code", 32'h0, 32'(attenCode));
        set_mode(32'h5);
        check("serialMode", 32'h1, 32'(serialMode));
        sweep();
        apply(7'h53);
        check("bits", {28'h0, COUNT_RESET}, {28'h0, bitsReceived});
        set_mode(32'h4);
        check("serialMode", 32'h0, 32'(serialMode));
        apply(7'h33);
        close_out();
    end

    // Watchdog
    initial begin
        #400000;
        mismatches++;
        close_out();
    end
endmodule // step_attenuator_control_tb

`default_nettype wire
